// ==== sch_pkg.sv ====
// Contract
// - Get-baud-rate returns the current actual baud rate as a 32-bit unsigned value.
// - Flow control is one byte, 0 none, 1 CTS/RTS; separate get and set messages.
// - Set-baud-rate takes a 32-bit target rate and reconfigures the serial port.
// - Save-serial-settings stores current baud and flow control as power-up defaults.
// - LED pattern message with no payload returns the top LED to default behaviour.
// - LED mode 0 default, 1 three long three short blinks, 2 slow fade.
// - User pattern drives only the top LED; higher-priority system patterns override it.
// - Reprogram message enters reprogramming state; device resets once reprogramming completes.
// - Abort during acquisition discards the scan and returns to idle.
// - Get-maximum-buffer-size returns the hardware spectrum capacity as 32-bit unsigned.
// - Get-current-buffer-size returns the programmed active depth as 32-bit unsigned.
// - Clear-buffer removes every accumulated spectrum.
// - Remove-oldest discards the given count of spectra, oldest first.
// - A remove count above the buffered number empties the whole buffer.
// - Set-active-buffer-size sets how many spectra fit before overflow.
// - Active depth is kept between 1 and the hardware limit.
// - Setting the active depth also clears the buffer.
package sch_pkg;
    // Clock and LED timing
    localparam int CLK_MHZ = 50;
    localparam int LED_TICK_US = 2000;
    localparam int LED_TICK_CYC = LED_TICK_US * CLK_MHZ;
    localparam logic [5:0] BLINK_STEP_LAST = 6'h31;
    localparam logic [4:0] BLINK_SLOT_LAST = 5'h13;
    localparam logic [19:0] BLINK_MASK = 20'h15777;
    localparam logic [7:0] FADE_TOP = 8'hFF;
    // Register byte offsets
    localparam logic [7:0] REG_MSG = 8'h00;
    localparam logic [7:0] REG_ARG = 8'h04;
    localparam logic [7:0] REG_LEN = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    // Status bit positions
    localparam int ST_ERR = 0;
    localparam int ST_REPROG = 1;
    localparam int ST_ACQ = 2;
    localparam int ST_FLOW = 3;
    localparam int ST_LED = 4;
    // Message types
    localparam logic [31:0] MSG_GET_BAUD = 32'h0000_0800;
    localparam logic [31:0] MSG_GET_FLOW = 32'h0000_0804;
    localparam logic [31:0] MSG_SET_BAUD = 32'h0000_0810;
    localparam logic [31:0] MSG_SET_FLOW = 32'h0000_0814;
    localparam logic [31:0] MSG_SAVE_SER = 32'h0000_08F0;
    localparam logic [31:0] MSG_SET_LED = 32'h0000_1010;
    localparam logic [31:0] MSG_REPROG = 32'h000F_FF00;
    localparam logic [31:0] MSG_ABORT = 32'h0010_0000;
    localparam logic [31:0] MSG_GET_MAXBUF = 32'h0010_0820;
    localparam logic [31:0] MSG_GET_CURBUF = 32'h0010_0822;
    localparam logic [31:0] MSG_CLR_BUF = 32'h0010_0830;
    localparam logic [31:0] MSG_DROP_OLD = 32'h0010_0831;
    localparam logic [31:0] MSG_SET_DEPTH = 32'h0010_0832;
    // Field values and reset values
    localparam logic [1:0] LED_DEFAULT = 2'h0;
    localparam logic [1:0] LED_BLINK = 2'h1;
    localparam logic [1:0] LED_FADE = 2'h2;
    localparam logic [7:0] FLOW_MAX = 8'h01;
    localparam logic [1:0] LEN_NONE = 2'h0;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [31:0] RST_BAUD = 32'h0001_C200;
    localparam logic [31:0] BUF_MAX_DEF = 32'h0000_0010;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== sch_led_if.sv ====
`timescale 1ns/1ps
interface sch_led_if;
    logic [1:0] mode;
    logic led_on;
    modport ctl (output mode, input led_on);
    modport gen (input mode, output led_on);
endinterface

// ==== sch_led_gen.sv ====
`timescale 1ns/1ps
module sch_led_gen #(
    parameter int TICK_CYC = sch_pkg::LED_TICK_CYC // Cycles per pattern tick
) (
    input wire logic ref_clk, // System clock
    input wire logic srst, // Synchronous reset
    sch_led_if.gen led_bus // Mode in, LED level out
);
    import sch_pkg::*;
    localparam int TW = $clog2(TICK_CYC);

    typedef struct packed {
        logic [TW-1:0] tick_cnt;
        logic [5:0] step;
        logic [4:0] slot;
        logic [7:0] pwm;
        logic [7:0] level;
        logic down;
        logic led_on;
    } sch_led_state_t;

    sch_led_state_t st_ff;
    sch_led_state_t nxt_st;
    logic tick;

    assign led_bus.led_on = st_ff.led_on;

    // Tick divider, blink slot sequencer, fade ramp and PWM
    always_comb begin
        nxt_st = st_ff;
        tick = (st_ff.tick_cnt == TW'(TICK_CYC - 1));
        nxt_st.tick_cnt = tick ? '0 : st_ff.tick_cnt + 1'b1;
        nxt_st.pwm = st_ff.pwm + 8'h01;
        if (tick) begin
            nxt_st.step = (st_ff.step == BLINK_STEP_LAST) ? 6'h00 : st_ff.step + 6'h01;
            if (st_ff.step == BLINK_STEP_LAST) begin
                nxt_st.slot = (st_ff.slot == BLINK_SLOT_LAST) ? 5'h00 : st_ff.slot + 5'h01;
            end
            // Ramp turns around at both ends so brightness never wraps
            if (st_ff.down) begin
                nxt_st.level = st_ff.level - 8'h01;
                nxt_st.down = (st_ff.level != 8'h01);
            end else begin
                nxt_st.level = st_ff.level + 8'h01;
                nxt_st.down = (st_ff.level == FADE_TOP - 8'h01);
            end
        end
        unique case (led_bus.mode)
            LED_BLINK: nxt_st.led_on = BLINK_MASK[st_ff.slot];
            LED_FADE: nxt_st.led_on = (st_ff.pwm < st_ff.level);
            default: nxt_st.led_on = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    a_blink_mask: assert property (@(posedge ref_clk) disable iff (srst)
        led_bus.mode == LED_BLINK |=> st_ff.led_on == BLINK_MASK[$past(st_ff.slot)])
        else $error("blink output does not follow pattern slot");
    a_fade_turn: assert property (@(posedge ref_clk) disable iff (srst)
        tick && st_ff.level == FADE_TOP - 8'h01 && !st_ff.down |=> st_ff.down)
        else $error("fade ramp did not turn at top");
endmodule

// ==== sch_cmd_handler.sv ====
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module sch_cmd_handler #(
    parameter logic [31:0] BUF_MAX = sch_pkg::BUF_MAX_DEF, // Hardware spectrum capacity
    parameter int LED_TICK = sch_pkg::LED_TICK_CYC // Cycles per LED pattern tick
) (
    input wire logic ref_clk, // System clock, 50 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic s_axil_awvalid, // Write address valid
    output logic s_axil_awready, // Write address ready
    input wire logic [7:0] s_axil_awaddr, // Write byte address
    input wire logic s_axil_wvalid, // Write data valid
    output logic s_axil_wready, // Write data ready
    input wire logic [31:0] s_axil_wdata, // Write data
    input wire logic [3:0] s_axil_wstrb, // Byte enables
    output logic s_axil_bvalid, // Write response valid
    input wire logic s_axil_bready, // Write response ready
    output logic [1:0] s_axil_bresp, // Write response code
    input wire logic s_axil_arvalid, // Read address valid
    output logic s_axil_arready, // Read address ready
    input wire logic [7:0] s_axil_araddr, // Read byte address
    output logic s_axil_rvalid, // Read data valid
    input wire logic s_axil_rready, // Read data ready
    output logic [31:0] s_axil_rdata, // Read data
    output logic [1:0] s_axil_rresp, // Read response code
    input wire logic [31:0] nv_baud, // Stored power-up baud rate
    input wire logic nv_flow, // Stored power-up flow mode
    output logic nv_save, // Pulse: store baud and flow
    output logic [31:0] baud_rate, // Current serial baud rate
    output logic flow_cts_rts, // Current flow mode
    output logic uart_reconfig, // Pulse: apply new serial setup
    input wire logic [1:0] sys_led_pri, // Priority of system pattern
    input wire logic sys_led, // System pattern level
    output logic top_led, // Top LED drive
    output logic reprog_mode, // Reprogramming state
    input wire logic reprog_done, // Reprogramming finished
    output logic sys_reset_req, // Reset request: high while reprogramming and reprog_done
    input wire logic acquiring, // Acquisition in progress
    output logic acq_abort, // Pulse: dump scan, go idle
    input wire logic [31:0] buf_count, // Spectra now buffered
    output logic buf_clear, // Pulse: empty buffer
    output logic buf_drop, // Pulse: drop oldest spectra
    output logic [31:0] buf_drop_cnt, // Number to drop
    output logic [31:0] buf_depth // Active buffer depth
);
    import sch_pkg::*;

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic bvalid;
        logic rvalid;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] arg;
        logic [1:0] arg_len;
        logic [31:0] result;
        logic err;
        logic init_done;
        logic [31:0] baud;
        logic flow;
        logic reconfig;
        logic save;
        logic [1:0] led_mode;
        logic led;
        logic reprog;
        logic sys_reset;
        logic abort;
        logic clear;
        logic drop;
        logic [31:0] drop_cnt;
        logic [31:0] depth;
    } sch_state_t;

    sch_state_t st_ff;
    sch_state_t nxt_st;
    logic exec;
    logic [31:0] msg;
    logic ok;
    logic [1:0] user_pri;

    sch_led_if led_bus ();

    sch_led_gen #(
        .TICK_CYC(LED_TICK)
    ) u_led (
        .ref_clk(ref_clk),
        .srst(srst),
        .led_bus(led_bus)
    );

    assign led_bus.mode = st_ff.led_mode;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Bus slave, message execution and LED arbitration
    always_comb begin
        nxt_st = st_ff;
        exec = 1'b0;
        msg = st_ff.wdata;
        ok = 1'b1;
        nxt_st.reconfig = 1'b0;
        nxt_st.save = 1'b0;
        nxt_st.sys_reset = 1'b0;
        nxt_st.abort = 1'b0;
        nxt_st.clear = 1'b0;
        nxt_st.drop = 1'b0;
        // Stored defaults are taken once, the cycle after reset leaves
        if (!st_ff.init_done) begin
            nxt_st.init_done = 1'b1;
            nxt_st.baud = nv_baud;
            nxt_st.flow = nv_flow;
        end
        if (s_axil_awvalid && st_ff.awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awready = 1'b0;
            nxt_st.awaddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && st_ff.wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wready = 1'b0;
            nxt_st.wdata = s_axil_wdata;
            nxt_st.wstrb = s_axil_wstrb;
        end
        // Address and data may arrive in either order; act once both are held
        if (nxt_st.aw_got && nxt_st.w_got) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = RESP_OKAY;
            msg = nxt_st.wdata;
            unique case (nxt_st.awaddr)
                REG_ARG: nxt_st.arg = lane_merge(st_ff.arg, nxt_st.wdata, nxt_st.wstrb);
                REG_LEN: begin
                    if (nxt_st.wstrb[0]) begin
                        nxt_st.arg_len = nxt_st.wdata[1:0];
                    end
                end
                // A message code is only meaningful whole
                REG_MSG: begin
                    if (nxt_st.wstrb == 4'hF) begin
                        exec = 1'b1;
                    end else begin
                        nxt_st.bresp = RESP_SLVERR;
                    end
                end
                REG_RESULT, REG_STATUS: ;
                default: nxt_st.bresp = RESP_SLVERR;
            endcase
        end
        if (st_ff.bvalid && s_axil_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end
        // Message decode; while reprogramming every message is refused
        if (exec && st_ff.reprog) begin
            ok = 1'b0;
        end else if (exec) begin
            unique case (msg)
                MSG_GET_BAUD: nxt_st.result = st_ff.baud;
                MSG_GET_FLOW: nxt_st.result = {31'h0, st_ff.flow};
                MSG_SET_BAUD: begin
                    nxt_st.baud = st_ff.arg;
                    nxt_st.reconfig = 1'b1;
                end
                MSG_SET_FLOW: begin
                    if (st_ff.arg[7:0] <= FLOW_MAX) begin
                        nxt_st.flow = st_ff.arg[0];
                        nxt_st.reconfig = 1'b1;
                    end else begin
                        ok = 1'b0;
                    end
                end
                MSG_SAVE_SER: nxt_st.save = 1'b1;
                MSG_SET_LED: begin
                    if (st_ff.arg_len == LEN_NONE) begin
                        nxt_st.led_mode = LED_DEFAULT;
                    end else if (st_ff.arg_len == LEN_TWO && st_ff.arg[7:0] == 8'h00
                                 && st_ff.arg[15:8] <= {6'h00, LED_FADE}) begin
                        nxt_st.led_mode = st_ff.arg[9:8];
                    end else begin
                        ok = 1'b0;
                    end
                end
                MSG_REPROG: nxt_st.reprog = 1'b1;
                MSG_ABORT: nxt_st.abort = acquiring;
                MSG_GET_MAXBUF: nxt_st.result = BUF_MAX;
                MSG_GET_CURBUF: nxt_st.result = st_ff.depth;
                MSG_CLR_BUF: nxt_st.clear = 1'b1;
                MSG_DROP_OLD: begin
                    nxt_st.drop = 1'b1;
                    nxt_st.drop_cnt = (st_ff.arg > buf_count) ? buf_count : st_ff.arg;
                end
                MSG_SET_DEPTH: begin
                    if (st_ff.arg != 32'h0 && st_ff.arg <= BUF_MAX) begin
                        nxt_st.depth = st_ff.arg;
                        nxt_st.clear = 1'b1;
                    end else begin
                        ok = 1'b0;
                    end
                end
                default: ok = 1'b0;
            endcase
        end
        if (exec) begin
            nxt_st.err = !ok;
        end
        // Reset request follows the end of reprogramming
        if (st_ff.reprog && reprog_done) begin
            nxt_st.sys_reset = 1'b1;
        end
        // Read channel: one read at a time, unmapped reads answer zero with error
        if (s_axil_arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            unique case (s_axil_araddr)
                REG_MSG: nxt_st.rdata = 32'h0;
                REG_ARG: nxt_st.rdata = st_ff.arg;
                REG_LEN: nxt_st.rdata = {30'h0, st_ff.arg_len};
                REG_RESULT: nxt_st.rdata = st_ff.result;
                REG_STATUS: nxt_st.rdata = {26'h0, st_ff.led_mode, st_ff.flow, acquiring,
                                            st_ff.reprog, st_ff.err};
                default: begin
                    nxt_st.rdata = 32'h0;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_ff.rvalid && s_axil_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        // User pattern yields to any system pattern of higher priority
        unique case (st_ff.led_mode)
            LED_BLINK: user_pri = 2'h2;
            LED_FADE: user_pri = 2'h1;
            default: user_pri = 2'h0;
        endcase
        if (st_ff.led_mode == LED_DEFAULT || sys_led_pri > user_pri) begin
            nxt_st.led = sys_led;
        end else begin
            nxt_st.led = led_bus.led_on;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_ff <= '0;
            st_ff.awready <= 1'b1;
            st_ff.wready <= 1'b1;
            st_ff.arready <= 1'b1;
            st_ff.baud <= RST_BAUD;
            st_ff.depth <= BUF_MAX;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axil_awready = st_ff.awready;
    assign s_axil_wready = st_ff.wready;
    assign s_axil_bvalid = st_ff.bvalid;
    assign s_axil_bresp = st_ff.bresp;
    assign s_axil_arready = st_ff.arready;
    assign s_axil_rvalid = st_ff.rvalid;
    assign s_axil_rdata = st_ff.rdata;
    assign s_axil_rresp = st_ff.rresp;
    assign nv_save = st_ff.save;
    assign baud_rate = st_ff.baud;
    assign flow_cts_rts = st_ff.flow;
    assign uart_reconfig = st_ff.reconfig;
    assign top_led = st_ff.led;
    assign reprog_mode = st_ff.reprog;
    assign sys_reset_req = st_ff.sys_reset;
    assign acq_abort = st_ff.abort;
    assign buf_clear = st_ff.clear;
    assign buf_drop = st_ff.drop;
    assign buf_drop_cnt = st_ff.drop_cnt;
    assign buf_depth = st_ff.depth;

    sequence s_exec(logic [31:0] code);
        exec && !st_ff.reprog && msg == code;
    endsequence

    a_get_baud: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_GET_BAUD) |=> st_ff.result == $past(st_ff.baud))
        else $error("baud query result wrong");
    a_baud_apply: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_SET_BAUD) |=> uart_reconfig && baud_rate == $past(st_ff.arg) ##1 !uart_reconfig)
        else $error("baud set not applied as one pulse");
    a_flow_reject: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_SET_FLOW) ##0 (st_ff.arg[7:0] > FLOW_MAX) |=> $stable(flow_cts_rts) && st_ff.err)
        else $error("illegal flow value changed setting");
    a_save_pulse: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_SAVE_SER) |=> nv_save ##1 !nv_save)
        else $error("save pulse missing");
    a_led_default: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_SET_LED) ##0 (st_ff.arg_len == LEN_NONE) |=> st_ff.led_mode == LED_DEFAULT)
        else $error("empty LED message did not restore default");
    a_led_override: assert property (@(posedge ref_clk) disable iff (srst)
        st_ff.led_mode == LED_FADE && sys_led_pri > 2'h1 |=> top_led == $past(sys_led))
        else $error("system pattern did not override user pattern");
    a_reprog_reset: assert property (@(posedge ref_clk) disable iff (srst)
        reprog_mode && reprog_done |=> sys_reset_req && reprog_mode)
        else $error("no reset request after reprogramming");
    a_abort_idle: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_ABORT) ##0 acquiring |=> acq_abort)
        else $error("abort not issued while acquiring");
    a_drop_clamp: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_DROP_OLD) |=> buf_drop && buf_drop_cnt <= $past(buf_count))
        else $error("drop count exceeds buffered spectra");
    a_depth_bounds: assert property (@(posedge ref_clk) disable iff (srst)
        buf_depth != 32'h0 && buf_depth <= BUF_MAX)
        else $error("active depth outside bounds");
    a_depth_clear: assert property (@(posedge ref_clk) disable iff (srst)
        s_exec(MSG_SET_DEPTH) ##0 (st_ff.arg != 32'h0 && st_ff.arg <= BUF_MAX)
        |=> buf_clear && buf_depth == $past(st_ff.arg))
        else $error("depth set did not clear buffer");
    a_bresp_hold: assert property (@(posedge ref_clk) disable iff (srst)
        s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped before accepted");
endmodule

// ==== sch_buf_model.sv ====
`timescale 1ns/1ps
// Stand-in for the spectrum store behind the handler
module sch_buf_model #(
    parameter int FILL = 5 // Spectra held after reset
) (
    input wire logic ref_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic buf_clear, // Empty request
    input wire logic buf_drop, // Drop request
    input wire logic [31:0] buf_drop_cnt, // Number to drop
    output logic [31:0] buf_count // Spectra held
);
    // Saturate at zero so an oversized count never wraps the store
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            buf_count <= 32'(FILL);
        end else if (buf_clear) begin
            buf_count <= 32'h0;
        end else if (buf_drop) begin
            buf_count <= (buf_drop_cnt > buf_count) ? 32'h0 : buf_count - buf_drop_cnt;
        end
    end
endmodule

// ==== tb_sch_cmd_handler.sv ====
`timescale 1ns/1ps
module tb_sch_cmd_handler;
    import sch_pkg::*;
    localparam logic [31:0] NVB = 32'h0000_2580; // Stored rate, 9600
    typedef struct {logic [31:0] act, arg, q, e;} sch_row_t;
    logic ref_clk, srst, awv, awr, wv, wr_, bv, bre, arv, arr, rv, rre, save, flow, cfg, sled, led;
    logic rpm, rdone, rstq, acq, abt, clr, drp;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdt, baud, dcnt, bcnt, dep, res;
    logic [1:0] br, rr, spri, resp, wresp;
    int err_total = 0, check_count = 0, n_clr = 0, n_cfg = 0, n_save = 0, n_ab = 0, n_rst = 0;
    // Query table: action, its argument, query, expected answer
    sch_row_t rows[8] = '{
        '{MSG_SET_BAUD, 32'h4B00, MSG_GET_BAUD, 32'h4B00},
        '{MSG_SET_FLOW, 32'h1, MSG_GET_FLOW, 32'h1},
        '{MSG_SET_FLOW, 32'h2, MSG_GET_FLOW, 32'h1},
        '{MSG_SET_FLOW, 32'h0, MSG_GET_FLOW, 32'h0},
        '{MSG_GET_MAXBUF, 32'h0, MSG_GET_MAXBUF, 32'h8},
        '{MSG_SET_DEPTH, 32'h0, MSG_GET_CURBUF, 32'h8},
        '{MSG_SET_DEPTH, 32'h9, MSG_GET_CURBUF, 32'h8},
        '{MSG_SET_DEPTH, 32'h1, MSG_GET_CURBUF, 32'h1}};
    sch_cmd_handler #(.BUF_MAX(32'h8), .LED_TICK(4)) dut (.ref_clk(ref_clk), .srst(srst),
        .s_axil_awvalid(awv), .s_axil_awready(awr), .s_axil_awaddr(awa), .s_axil_wvalid(wv),
        .s_axil_wready(wr_), .s_axil_wdata(wd), .s_axil_wstrb(4'hF), .s_axil_bvalid(bv),
        .s_axil_bready(bre), .s_axil_bresp(br), .s_axil_arvalid(arv), .s_axil_arready(arr),
        .s_axil_araddr(ara), .s_axil_rvalid(rv), .s_axil_rready(rre), .s_axil_rdata(rdt),
        .s_axil_rresp(rr), .nv_baud(NVB), .nv_flow(1'h0), .nv_save(save), .baud_rate(baud),
        .flow_cts_rts(flow), .uart_reconfig(cfg), .sys_led_pri(spri), .sys_led(sled), .top_led(led),
        .reprog_mode(rpm), .reprog_done(rdone), .sys_reset_req(rstq), .acquiring(acq),
        .acq_abort(abt), .buf_count(bcnt), .buf_clear(clr), .buf_drop(drp), .buf_drop_cnt(dcnt),
        .buf_depth(dep));
    sch_buf_model #(.FILL(5)) bm (.ref_clk(ref_clk), .srst(srst), .buf_clear(clr), .buf_drop(drp),
        .buf_drop_cnt(dcnt), .buf_count(bcnt));
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Pulses last one cycle (the reset request stays high while reprog_done is high), so count them rather than poll
    always @(posedge ref_clk) begin
        n_clr <= n_clr + int'(clr);
        n_cfg <= n_cfg + int'(cfg);
        n_save <= n_save + int'(save);
        n_ab <= n_ab + int'(abt);
        n_rst <= n_rst + int'(rstq);
    end
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // A bound that runs out ends the run as a failure
    task automatic stall(input int n);
        if (n >= 50) begin
            err_total++;
            $display("Error handshake expected 1 seen 0");
            tally_and_finish;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        awv <= 1'h1;
        wv <= 1'h1;
        bre <= 1'h1;
        awa <= a;
        wd <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awr) awv <= 1'h0;
            if (wr_) wv <= 1'h0;
            if (bv) begin
                wresp = br;
                break;
            end
        end
        bre <= 1'h0;
        stall(n);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge ref_clk);
        arv <= 1'h1;
        rre <= 1'h1;
        ara <= a;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arr) arv <= 1'h0;
            if (rv) break;
        end
        d = rdt;
        r = rr;
        rre <= 1'h0;
        stall(n);
    endtask
    // Payload and length go in before the code that runs the message
    task automatic msg(input logic [31:0] c, input logic [31:0] a, input logic [1:0] l);
        wr(REG_ARG, a);
        wr(REG_LEN, {30'h0, l});
        wr(REG_MSG, c);
        // One more edge so the model and the pulse counters have taken the effect
        @(posedge ref_clk);
    endtask
    initial begin
        {srst, awv, wv, bre, arv, rre, sled, rdone, acq} = 9'h1FF & 9'h100;
        {awa, ara, wd, spri} = 50'h0;
        repeat (20) @(posedge ref_clk);
        srst <= 1'h0;
        repeat (3) @(posedge ref_clk);
        chk("baud", NVB, baud);
        chk("depth", 32'h8, dep);
        $display("Test reset done");
        msg(MSG_DROP_OLD, 32'h2, 2'h0);
        chk("count", 32'h3, bcnt);
        msg(MSG_DROP_OLD, 32'hA, 2'h0);
        chk("drop cnt", 32'h3, dcnt);
        chk("count", 32'h0, bcnt);
        msg(MSG_CLR_BUF, 32'h0, 2'h0);
        chk("clears", 32'h1, n_clr);
        msg(MSG_SAVE_SER, 32'h0, 2'h0);
        chk("saves", 32'h1, n_save);
        $display("Test buffer done");
        foreach (rows[i]) begin
            msg(rows[i].act, rows[i].arg, 2'h0);
            msg(rows[i].q, 32'h0, 2'h0);
            rd(REG_RESULT, res, resp);
            chk("result", rows[i].e, res);
        end
        chk("reconfigs", 32'h3, n_cfg);
        chk("clears", 32'h2, n_clr);
        chk("baud pin", 32'h4B00, baud);
        msg(MSG_SET_FLOW, 32'h1, 2'h0);
        chk("flow pin", 32'h1, {31'h0, flow});
        $display("Test table done");
        sled <= 1'h1;
        msg(MSG_SET_LED, 32'h0, 2'h0);
        repeat (4) @(posedge ref_clk);
        chk("led", 32'h1, {31'h0, led});
        for (int m = 2; m > 0; m--) begin
            msg(MSG_SET_LED, 32'(m) << 8, 2'h2);
            rd(REG_STATUS, res, resp);
            chk("led mode", 32'(m), {30'h0, res[5:4]});
        end
        msg(MSG_SET_LED, 32'h0201, 2'h2);
        rd(REG_STATUS, res, resp);
        chk("status", 32'h19, {26'h0, res[5:0]});
        spri <= 2'h3;
        sled <= 1'h0;
        repeat (4) @(posedge ref_clk);
        chk("led", 32'h0, {31'h0, led});
        sled <= 1'h1;
        repeat (4) @(posedge ref_clk);
        chk("led", 32'h1, {31'h0, led});
        $display("Test led done");
        acq <= 1'h1;
        // No spectra are asked for after the abort, as the host side must keep
        msg(MSG_ABORT, 32'h0, 2'h0);
        chk("aborts", 32'h1, n_ab);
        rd(8'h20, res, resp);
        chk("bad addr", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr(8'h24, 32'h0);
        chk("bad wr", {30'h0, RESP_SLVERR}, {30'h0, wresp});
        msg(MSG_REPROG, 32'h0, 2'h0);
        rd(REG_STATUS, res, resp);
        chk("reprog", 32'h1, {31'h0, res[1]});
        chk("reprog pin", 32'h1, {31'h0, rpm});
        rdone <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk("reset req", 32'h1, 32'(n_rst > 0));
        $display("Test misc done");
        tally_and_finish;
    end
endmodule
